// ---- logic/tcc_unit.sv ----
`default_nettype none
module tcc_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_tick,
   input wire logic capture_pin,
   input wire logic [1:0] port_out,
   input wire logic [1:0] compare_pin_direction,
   input wire logic capture_irq_ack,
   input wire logic [1:0] compare_irq_ack,
   output logic [1:0] compare_output,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe_n,
   output logic capture_irq,
   output logic [1:0] compare_irq
);

   function automatic logic tcc_is_pwm(input logic [3:0] m);
      tcc_is_pwm = !(m == tcc_pkg::MODE_NORMAL || m == tcc_pkg::MODE_CTC_CMP ||
                     m == tcc_pkg::MODE_CTC_CAP || m == tcc_pkg::MODE_RESERVED);
   endfunction

   function automatic logic tcc_dual_slope(input logic [3:0] m);
      tcc_dual_slope = (m == tcc_pkg::MODE_PC_8) || (m == tcc_pkg::MODE_PC_9) ||
                       (m == tcc_pkg::MODE_PC_10) || (m == tcc_pkg::MODE_PFC_CAP) ||
                       (m == tcc_pkg::MODE_PFC_CMP) || (m == tcc_pkg::MODE_PC_CAP) ||
                       (m == tcc_pkg::MODE_PC_CMP);
   endfunction

   // top-defined-by-capture modes also take the capture register off the edge path
   function automatic logic tcc_cap_is_top(input logic [3:0] m);
      tcc_cap_is_top = (m == tcc_pkg::MODE_CTC_CAP) || (m == tcc_pkg::MODE_FAST_CAP) ||
                       (m == tcc_pkg::MODE_PFC_CAP) || (m == tcc_pkg::MODE_PC_CAP);
   endfunction

   function automatic logic [15:0] tcc_top(input logic [3:0] m, input logic [15:0] cmp_a,
                                           input logic [15:0] cap_v);
      case (m)
         tcc_pkg::MODE_PC_8, tcc_pkg::MODE_FAST_8: tcc_top = tcc_pkg::TOP_8BIT;
         tcc_pkg::MODE_PC_9, tcc_pkg::MODE_FAST_9: tcc_top = tcc_pkg::TOP_9BIT;
         tcc_pkg::MODE_PC_10, tcc_pkg::MODE_FAST_10: tcc_top = tcc_pkg::TOP_10BIT;
         tcc_pkg::MODE_CTC_CMP, tcc_pkg::MODE_PFC_CMP, tcc_pkg::MODE_PC_CMP,
         tcc_pkg::MODE_FAST_CMP: tcc_top = cmp_a;
         tcc_pkg::MODE_CTC_CAP, tcc_pkg::MODE_PFC_CAP, tcc_pkg::MODE_PC_CAP,
         tcc_pkg::MODE_FAST_CAP: tcc_top = cap_v;
         default: tcc_top = tcc_pkg::TOP_MAX;
      endcase
   endfunction

   // phase and frequency correct modes reload at bottom, all other PWM modes at top
   function automatic logic tcc_load_at_bottom(input logic [3:0] m);
      tcc_load_at_bottom = (m == tcc_pkg::MODE_PFC_CAP) || (m == tcc_pkg::MODE_PFC_CMP);
   endfunction

   // non-PWM action applied by a real or forced match
   function automatic logic tcc_plain_action(input logic [1:0] a, input logic cur);
      case (a)
         tcc_pkg::ACT_TOGGLE: tcc_plain_action = !cur;
         tcc_pkg::ACT_CLEAR: tcc_plain_action = 1'b0;
         tcc_pkg::ACT_SET: tcc_plain_action = 1'b1;
         default: tcc_plain_action = cur;
      endcase
   endfunction

   tcc_pkg::tcc_state_t s, next_s;

   logic setup_phase;
   logic access_phase;
   logic [7:0] addr;
   logic addr_ok;
   logic [15:0] top;
   logic edge_src;

   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign addr = paddr[7:0];
   assign top = tcc_top(s.wmode, s.cmp_act[0], s.cap);
   assign edge_src = s.filt_en ? s.filt : s.hist[0];

   always_comb begin
      addr_ok = (paddr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) &&
                (addr <= tcc_pkg::OFS_IRQ_EN);
   end

   always_comb begin
      logic pwm;
      logic at_top;
      logic at_bottom;
      logic load_now;
      logic cap_evt;
      logic [1:0] match;
      logic [1:0] force_hit;
      logic [7:0] ofs_lo;
      logic [7:0] ofs_hi;
      logic [15:0] cur;
      next_s = s;
      pwm = tcc_is_pwm(s.wmode);
      at_top = (s.count == top);
      at_bottom = (s.count == tcc_pkg::BOTTOM);
      load_now = 1'b0;
      cap_evt = 1'b0;
      match = 2'h0;
      force_hit = 2'h0;
      ofs_lo = 8'h00;
      ofs_hi = 8'h00;
      cur = 16'h0000;

      // capture path on the system clock; action bits play no part here
      next_s.hist = {s.hist[2:0], capture_pin};
      if (&s.hist || !(|s.hist)) begin
         next_s.filt = s.hist[0];
      end
      next_s.prev = edge_src;
      cap_evt = (edge_src != s.prev) && (edge_src == s.edge_rise) &&
                !tcc_cap_is_top(s.wmode);
      if (cap_evt) begin
         next_s.cap = s.count;
      end

      // counter and comparators advance only on a timer tick
      if (timer_tick) begin
         next_s.block = 1'b0;
         if (s.block) begin
            // blocked tick: no match, no top, count keeps going
            next_s.count = s.down ? s.count - 16'h0001 : s.count + 16'h0001;
         end else begin
            if (tcc_dual_slope(s.wmode)) begin
               if (!s.down && at_top) begin
                  next_s.down = 1'b1;
                  next_s.count = s.count - 16'h0001;
               end else if (s.down && at_bottom) begin
                  next_s.down = 1'b0;
                  next_s.count = s.count + 16'h0001;
               end else begin
                  next_s.count = s.down ? s.count - 16'h0001 : s.count + 16'h0001;
               end
            end else begin
               next_s.down = 1'b0;
               next_s.count = at_top ? tcc_pkg::BOTTOM : s.count + 16'h0001;
            end
            load_now = pwm && (tcc_load_at_bottom(s.wmode) ? at_bottom : at_top);
            for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
               match[ch] = (s.count == s.cmp_act[ch]);
            end
         end
      end

      // output unit: action bits read live every cycle
      for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
         if (match[ch]) begin
            next_s.cmp_flag[ch] = 1'b1;
            if (!pwm) begin
               next_s.oc[ch] = tcc_plain_action(s.act[ch], s.oc[ch]);
            end else if (tcc_dual_slope(s.wmode)) begin
               if (s.act[ch] == tcc_pkg::ACT_CLEAR) begin
                  next_s.oc[ch] = s.down;
               end else if (s.act[ch] == tcc_pkg::ACT_SET) begin
                  next_s.oc[ch] = !s.down;
               end
            end else if (s.act[ch] == tcc_pkg::ACT_CLEAR) begin
               next_s.oc[ch] = 1'b1;
            end else if (s.act[ch] == tcc_pkg::ACT_SET) begin
               next_s.oc[ch] = 1'b0;
            end
         end
         // single-slope PWM restores the level at top; a top match wins over the compare match
         if (timer_tick && !s.block && pwm && !tcc_dual_slope(s.wmode) && at_top) begin
            if (s.act[ch] == tcc_pkg::ACT_CLEAR) begin
               next_s.oc[ch] = 1'b0;
            end else if (s.act[ch] == tcc_pkg::ACT_SET) begin
               next_s.oc[ch] = 1'b1;
            end
         end
         if (load_now) begin
            next_s.cmp_act[ch] = s.cmp_buf[ch];
         end
      end

      // register writes take effect at the access edge
      if (access_phase && pwrite && addr_ok) begin
         if (addr == tcc_pkg::OFS_CTRL) begin
            // mode change leaves the output state alone
            next_s.wmode = pwdata[tcc_pkg::CTRL_MODE_LSB +: 4];
            next_s.filt_en = pwdata[tcc_pkg::CTRL_FILT_BIT];
            next_s.edge_rise = pwdata[tcc_pkg::CTRL_EDGE_BIT];
         end
         if (addr == tcc_pkg::OFS_ACTION) begin
            next_s.act = pwdata[2 * tcc_pkg::ACTION_W - 1:0];
         end
         if (addr == tcc_pkg::OFS_COUNT) begin
            // cpu write beats any count or clear in the same cycle
            next_s.count = pwdata[15:0];
            next_s.block = 1'b1;
         end
         if (addr == tcc_pkg::OFS_CAP_HIGH) begin
            next_s.latch = pwdata[7:0];
         end
         if (addr == tcc_pkg::OFS_CAP_LOW && tcc_cap_is_top(s.wmode)) begin
            next_s.cap = {s.latch, pwdata[7:0]};
         end
         for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
            ofs_lo = tcc_pkg::OFS_CMP_LOW + 8'(ch) * tcc_pkg::OFS_CMP_STRIDE;
            ofs_hi = tcc_pkg::OFS_CMP_HIGH + 8'(ch) * tcc_pkg::OFS_CMP_STRIDE;
            if (addr == ofs_hi) begin
               next_s.latch = pwdata[7:0];
            end
            if (addr == ofs_lo) begin
               if (pwm) begin
                  next_s.cmp_buf[ch] = {s.latch, pwdata[7:0]};
               end else begin
                  next_s.cmp_act[ch] = {s.latch, pwdata[7:0]};
                  next_s.cmp_buf[ch] = {s.latch, pwdata[7:0]};
               end
            end
            if (addr == tcc_pkg::OFS_FORCE && pwdata[ch] && !pwm) begin
               next_s.oc[ch] = tcc_plain_action(s.act[ch], s.oc[ch]);
            end
         end
         if (addr == tcc_pkg::OFS_IRQ_EN) begin
            next_s.irq_en = pwdata[2:0];
         end
      end

      // flags: write-one or service clears, a same-cycle event wins
      if (access_phase && pwrite && addr_ok && addr == tcc_pkg::OFS_FLAGS) begin
         if (pwdata[tcc_pkg::FLAG_CAP_BIT]) begin
            next_s.cap_flag = 1'b0;
         end
         for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
            if (pwdata[tcc_pkg::FLAG_CMP_LSB + ch]) begin
               next_s.cmp_flag[ch] = 1'b0;
            end
         end
      end
      if (capture_irq_ack) begin
         next_s.cap_flag = 1'b0;
      end
      for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
         if (compare_irq_ack[ch]) begin
            next_s.cmp_flag[ch] = 1'b0;
         end
         if (match[ch]) begin
            next_s.cmp_flag[ch] = 1'b1;
         end
      end
      if (cap_evt) begin
         next_s.cap_flag = 1'b1;
      end

      // read data is sampled in the setup cycle and presented through the access phase
      if (setup_phase) begin
         next_s.rdata = 32'h00000000;
         case (addr)
            tcc_pkg::OFS_CTRL: next_s.rdata[5:0] = {s.edge_rise, s.filt_en, s.wmode};
            tcc_pkg::OFS_ACTION: next_s.rdata[3:0] = s.act;
            tcc_pkg::OFS_COUNT: next_s.rdata[15:0] = s.count;
            tcc_pkg::OFS_CAP_LOW: next_s.rdata[7:0] = s.cap[7:0];
            tcc_pkg::OFS_CAP_HIGH: next_s.rdata[7:0] = s.cap[15:8];
            tcc_pkg::OFS_FLAGS: next_s.rdata[2:0] = {s.cmp_flag, s.cap_flag};
            tcc_pkg::OFS_IRQ_EN: next_s.rdata[2:0] = s.irq_en;
            default: next_s.rdata = 32'h00000000;
         endcase
         for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
            ofs_lo = tcc_pkg::OFS_CMP_LOW + 8'(ch) * tcc_pkg::OFS_CMP_STRIDE;
            ofs_hi = tcc_pkg::OFS_CMP_HIGH + 8'(ch) * tcc_pkg::OFS_CMP_STRIDE;
            cur = pwm ? s.cmp_buf[ch] : s.cmp_act[ch];
            if (addr == ofs_lo) begin
               next_s.rdata[7:0] = cur[7:0];
            end
            if (addr == ofs_hi) begin
               next_s.rdata[7:0] = cur[15:8];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.rdata;
   assign pready = access_phase;
   assign pslverr = access_phase && !addr_ok;
   assign compare_output = s.oc;
   assign capture_irq = s.cap_flag && s.irq_en[tcc_pkg::FLAG_CAP_BIT];
   assign compare_irq = s.cmp_flag & s.irq_en[2:1];

   generate
      for (genvar ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin : g_pin
         // override the port value only; direction is never taken over
         assign pin_out[ch] = (s.act[ch] != tcc_pkg::ACT_NONE) ? s.oc[ch] : port_out[ch];
         assign pin_oe_n[ch] = !compare_pin_direction[ch];
      end
   endgenerate

endmodule
`default_nettype wire

// ---- logic/tcc_pkg.sv ----
`default_nettype none
package tcc_pkg;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int CHANNELS = 2;
   localparam int FILT_SAMPLES = 4;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ACTION = 8'h04;
   localparam logic [7:0] OFS_FORCE = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0C;
   localparam logic [7:0] OFS_CMP_LOW = 8'h10;
   localparam logic [7:0] OFS_CMP_HIGH = 8'h14;
   localparam logic [7:0] OFS_CMP_STRIDE = 8'h08;
   localparam logic [7:0] OFS_CAP_LOW = 8'h20;
   localparam logic [7:0] OFS_CAP_HIGH = 8'h24;
   localparam logic [7:0] OFS_FLAGS = 8'h28;
   localparam logic [7:0] OFS_IRQ_EN = 8'h2C;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FILT_BIT = 4;
   localparam int CTRL_EDGE_BIT = 5;
   localparam int ACTION_W = 2;
   localparam int FLAG_CAP_BIT = 0;
   localparam int FLAG_CMP_LSB = 1;

   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_CMP = 4'h4;
   localparam logic [3:0] MODE_CTC_CAP = 4'hC;
   localparam logic [3:0] MODE_RESERVED = 4'hD;
   localparam logic [3:0] MODE_FAST_CAP = 4'hE;
   localparam logic [3:0] MODE_FAST_CMP = 4'hF;
   localparam logic [3:0] MODE_PC_8 = 4'h1;
   localparam logic [3:0] MODE_PC_9 = 4'h2;
   localparam logic [3:0] MODE_PC_10 = 4'h3;
   localparam logic [3:0] MODE_FAST_8 = 4'h5;
   localparam logic [3:0] MODE_FAST_9 = 4'h6;
   localparam logic [3:0] MODE_FAST_10 = 4'h7;
   localparam logic [3:0] MODE_PFC_CAP = 4'h8;
   localparam logic [3:0] MODE_PFC_CMP = 4'h9;
   localparam logic [3:0] MODE_PC_CAP = 4'hA;
   localparam logic [3:0] MODE_PC_CMP = 4'hB;

   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] BOTTOM = 16'h0000;

   typedef struct packed {
      logic [3:0] wmode;
      logic filt_en;
      logic edge_rise;
      logic [1:0][1:0] act;
      logic [15:0] count;
      logic down;
      logic block;
      logic [7:0] latch;
      logic [1:0][15:0] cmp_buf;
      logic [1:0][15:0] cmp_act;
      logic [15:0] cap;
      logic [3:0] hist;
      logic filt;
      logic prev;
      logic cap_flag;
      logic [1:0] cmp_flag;
      logic [2:0] irq_en;
      logic [1:0] oc;
      logic [31:0] rdata;
   } tcc_state_t;
endpackage
`default_nettype wire

// ---- tb/tcc_unit_monitor.sv ----
`default_nettype none
module tcc_unit_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_tick,
   input wire logic [1:0] port_out,
   input wire logic [1:0] compare_pin_direction,
   input wire logic [1:0] compare_irq_ack,
   input wire logic [1:0] compare_output,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n,
   input wire logic [1:0] compare_irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic apb_wr = psel & penable & pwrite;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   property p_oc_reset;
      $rose(presetn) |-> compare_output == 2'h0;
   endproperty
   a_oc_reset: assert property (p_oc_reset) else $error("compare output not cleared");
   property p_ready;
      s_access |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access phase without ready");
   property p_err_phase;
      pslverr |-> s_access;
   endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access");
   property p_rdata;
      $changed(prdata) |-> $past(psel && !penable);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved outside setup");
   property p_oe;
      pin_oe_n == ~compare_pin_direction;
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable not from direction");
   property p_pin_src;
      ((pin_out ^ compare_output) & (pin_out ^ port_out)) == 2'h0;
   endproperty
   a_pin_src: assert property (p_pin_src) else $error("pin from unknown source");
   property p_oc_cause;
      $changed(compare_output) |-> $past(timer_tick) || $past(apb_wr);
   endproperty
   a_oc_cause: assert property (p_oc_cause) else $error("output moved without cause");
   property p_flag_tick;
      $rose(compare_irq[0]) && !$past(apb_wr) |-> $past(timer_tick);
   endproperty
   a_flag_tick: assert property (p_flag_tick) else $error("compare flag set off tick");
   property p_ack;
      compare_irq[0] && compare_irq_ack[0] && !timer_tick |=> !compare_irq[0];
   endproperty
   a_ack: assert property (p_ack) else $error("serviced flag stayed");
endmodule
bind tcc_unit tcc_unit_monitor u_tcc_unit_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .timer_tick, .port_out, .compare_pin_direction,
   .compare_irq_ack, .compare_output, .pin_out, .pin_oe_n, .compare_irq);
`default_nettype wire

// ---- tb/tcc_cpu_model.sv ----
`default_nettype none
module tcc_cpu_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   // always one idle cycle after a transfer, so no signal is driven twice in one step
   task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h000000, ofs};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~{24'h000000, ofs};
      pwdata <= ~wd;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_tcc_unit.sv ----
`default_nettype none
module tb_tcc_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, rerr, capture_irq;
   logic [31:0] paddr, pwdata, prdata, rdv;
   logic timer_tick = 1'b0;
   logic capture_pin = 1'b0;
   logic [1:0] port_out = 2'h2;
   logic [1:0] compare_pin_direction = 2'h1;
   logic capture_irq_ack = 1'b0;
   logic [1:0] compare_irq_ack = 2'h0;
   logic [1:0] compare_output, pin_out, pin_oe_n, compare_irq;
   logic [1:0] acts [4] = '{tcc_pkg::ACT_SET, tcc_pkg::ACT_NONE, tcc_pkg::ACT_CLEAR,
      tcc_pkg::ACT_TOGGLE};
   logic [3:0] oc_exp = 4'hB;
   int err_total = 0;
   int checks_done = 0;
   always #10 pclk = ~pclk;
   tcc_unit u_tcc_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .timer_tick, .capture_pin, .port_out, .compare_pin_direction,
      .capture_irq_ack, .compare_irq_ack, .compare_output, .pin_out, .pin_oe_n, .capture_irq,
      .compare_irq);
   tcc_cpu_model u_tcc_cpu_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      u_tcc_cpu_model.xfer(1'b1, ofs, d, rdv, rerr);
   endtask
   task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp);
      u_tcc_cpu_model.xfer(1'b0, ofs, 32'h0, rdv, rerr);
      chk(rdv, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         timer_tick <= 1'b1;
         @(posedge pclk);
         timer_tick <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // flag must appear exactly n edges after the pin moves
   task automatic cap_at(input logic v, input int n);
      capture_pin <= v;
      repeat (n - 1) @(posedge pclk);
      #1 chk(capture_irq, 0);
      @(posedge pclk);
      #1 chk(capture_irq, 1);
      @(posedge pclk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #100us;
      err_total++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(compare_output, 0);
      chk(pin_oe_n, 2'h2);
      rchk(tcc_pkg::OFS_ACTION, 0);
      u_tcc_cpu_model.xfer(1'b0, 8'h30, 32'h0, rdv, rerr);
      chk(rerr, 1);
      $display("test reset done");
      wr(tcc_pkg::OFS_CMP_HIGH, 32'h12);
      wr(tcc_pkg::OFS_CMP_LOW, 32'h34);
      wr(tcc_pkg::OFS_CMP_LOW + tcc_pkg::OFS_CMP_STRIDE, 32'h56);
      rchk(tcc_pkg::OFS_CMP_LOW, 32'h34);
      rchk(tcc_pkg::OFS_CMP_HIGH, 32'h12);
      rchk(tcc_pkg::OFS_CMP_HIGH + tcc_pkg::OFS_CMP_STRIDE, 32'h12);
      $display("test latch done");
      wr(tcc_pkg::OFS_IRQ_EN, 32'h7);
      wr(tcc_pkg::OFS_ACTION, 32'h1);
      wr(tcc_pkg::OFS_COUNT, 32'h1230);
      tick(4);
      chk(compare_irq, 0);
      tick(1);
      chk(compare_irq, 2'h1);
      chk(compare_output, 2'h1);
      chk(pin_out, 2'h3);
      compare_irq_ack <= 2'h1;
      @(posedge pclk);
      compare_irq_ack <= 2'h0;
      @(posedge pclk);
      chk(compare_irq, 0);
      wr(tcc_pkg::OFS_COUNT, 32'h1234);
      tick(1);
      chk(compare_irq, 0);
      chk(compare_output, 2'h1);
      wr(tcc_pkg::OFS_COUNT, 32'h1233);
      tick(2);
      chk(compare_irq, 2'h1);
      wr(tcc_pkg::OFS_FLAGS, 32'h2);
      chk(compare_irq, 0);
      $display("test match done");
      for (int i = 0; i < 4; i++) begin
         wr(tcc_pkg::OFS_ACTION, {30'h0, acts[i]});
         wr(tcc_pkg::OFS_FORCE, 32'h1);
         chk(compare_output, {1'b0, oc_exp[i]});
         chk(pin_out, {1'b1, (acts[i] != 2'h0) ? oc_exp[i] : 1'b0});
         chk(compare_irq, 0);
      end
      $display("test force done");
      wr(tcc_pkg::OFS_CTRL, {28'h0, tcc_pkg::MODE_FAST_8});
      chk(compare_output, 2'h1);
      wr(tcc_pkg::OFS_FORCE, 32'h1);
      chk(compare_output, 2'h1);
      wr(tcc_pkg::OFS_COUNT, 32'h5);
      wr(tcc_pkg::OFS_CMP_HIGH + tcc_pkg::OFS_CMP_STRIDE, 32'h0);
      wr(tcc_pkg::OFS_CMP_LOW + tcc_pkg::OFS_CMP_STRIDE, 32'h10);
      rchk(tcc_pkg::OFS_CMP_LOW + tcc_pkg::OFS_CMP_STRIDE, 32'h10);
      tick(12);
      chk(compare_irq, 0);
      tick(255);
      chk(compare_irq, 0);
      tick(1);
      chk(compare_irq, 2'h2);
      $display("test buffer done");
      wr(tcc_pkg::OFS_CTRL, 32'h20);
      wr(tcc_pkg::OFS_COUNT, 32'h100);
      wr(tcc_pkg::OFS_FLAGS, 32'h7);
      cap_at(1'b1, 2);
      rchk(tcc_pkg::OFS_CAP_LOW, 32'h0);
      rchk(tcc_pkg::OFS_CAP_HIGH, 32'h1);
      capture_irq_ack <= 1'b1;
      @(posedge pclk);
      capture_irq_ack <= 1'b0;
      @(posedge pclk);
      chk(capture_irq, 0);
      wr(tcc_pkg::OFS_CTRL, 32'h0);
      wr(tcc_pkg::OFS_FLAGS, 32'h1);
      wr(tcc_pkg::OFS_COUNT, 32'h200);
      cap_at(1'b0, 2);
      wr(tcc_pkg::OFS_COUNT, 32'h300);
      wr(tcc_pkg::OFS_FLAGS, 32'h1);
      capture_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(capture_irq, 0);
      cap_at(1'b0, 2);
      rchk(tcc_pkg::OFS_CAP_HIGH, 32'h3);
      wr(tcc_pkg::OFS_CTRL, 32'h30);
      wr(tcc_pkg::OFS_FLAGS, 32'h1);
      capture_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      capture_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(capture_irq, 0);
      cap_at(1'b1, 6);
      $display("test capture done");
      give_verdict();
   end
endmodule
`default_nettype wire
